/* hw/pis_pkg.sv */
package pis_pkg;

  // clock and stage timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int NVM_RST_TIME_NS = 200;
  localparam int IN_RST_TIME_NS = 100;
  localparam int LUT_RST_TIME_NS = 100;
  localparam int SEQ_INIT_TIME_NS = 200;
  localparam int OUT_REL_TIME_NS = 40;
  localparam int NVM_RST_CYC = (NVM_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IN_RST_CYC = (IN_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LUT_RST_CYC = (LUT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_INIT_CYC = (SEQ_INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_REL_CYC = (OUT_REL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // timer width and default pin count
  localparam int TMR_W = 8;
  localparam int PIN_NUM = 9;

  // reset values
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

  typedef enum {
    PIS_OFF,
    PIS_NVM_RST,
    PIS_CFG_LOAD,
    PIS_IN_RST,
    PIS_IN_EN,
    PIS_LUT_RST,
    PIS_LUT_EN,
    PIS_SEQ_INIT,
    PIS_PWR_GOOD,
    PIS_RUN
  } pis_state_e;

  // control lines toward the macrocells and configuration memory
  typedef struct packed {
    logic macro_power;
    logic macro_reset;
    logic nvm_reset;
    logic cfg_load;
    logic in_reset;
    logic in_enable;
    logic analog_comparator_enable;
    logic pull_enable;
    logic lut_reset;
    logic lut_enable;
    logic edge_det_enable;
    logic seq_reset;
    logic seq_enable;
    logic power_good;
  } pis_ctrl_s;

  localparam pis_ctrl_s CTRL_RESET = '0;

endpackage

/* hw/pis_stage_timer.sv */
`timescale 1ns/100ps
// one-shot down counter; done pulses once when a loaded count expires
module pis_stage_timer #(
  parameter int WIDTH = pis_pkg::TMR_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  input wire logic abort_in,
  // status
  output logic done_out
);

  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end
    else if (abort_in)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end
    else if (load_in)
    begin
      cnt_reg <= count_in;
      run_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      if (cnt_reg <= WIDTH'(1))
        run_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      done_out <= 1'b0;
    else
      done_out <= run_reg && !load_in && !abort_in && (cnt_reg <= WIDTH'(1));
  end

endmodule

/* hw/pis_sequencer.sv */
`timescale 1ns/100ps
module pis_sequencer #(
  parameter int PIN_NUM = pis_pkg::PIN_NUM,
  parameter int NVM_RST_CYC = pis_pkg::NVM_RST_CYC,
  parameter int IN_RST_CYC = pis_pkg::IN_RST_CYC,
  parameter int LUT_RST_CYC = pis_pkg::LUT_RST_CYC,
  parameter int SEQ_INIT_CYC = pis_pkg::SEQ_INIT_CYC,
  parameter int OUT_REL_CYC = pis_pkg::OUT_REL_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // supply detect: high above power-on level, low below power-off level
  input wire logic supply_ok_in,
  // configuration memory handshake
  input wire logic cfg_load_done_in,
  // programmed pin configuration and core logic
  input wire logic [PIN_NUM-1:0] pin_is_output_in,
  input wire logic [PIN_NUM-1:0] core_data_in,
  // raw input pin levels and raw lookup table results
  input wire logic [PIN_NUM-1:0] pin_level_in,
  input wire logic lut_result_in,
  // macrocell and memory controls
  output pis_pkg::pis_ctrl_s ctrl_out,
  // gated levels seen by the routing matrix
  output logic [PIN_NUM-1:0] pin_to_matrix_out,
  output logic lut_to_matrix_out,
  // output pin drive
  output logic [PIN_NUM-1:0] pin_oe_out,
  output logic [PIN_NUM-1:0] pin_do_out,
  // sequencer status
  output logic init_busy_out
);

  localparam int TW = pis_pkg::TMR_W;

  logic [1:0] rst_sync_reg;
  logic rst_b;
  pis_pkg::pis_state_e state_reg;
  pis_pkg::pis_state_e state_next;
  pis_pkg::pis_ctrl_s ctrl_next;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_done;
  logic supply_lost;

  // reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rst_sync_reg <= pis_pkg::RST_SYNC_INIT;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_b = rst_sync_reg[1];

  // a supply drop wins over every stage so pins never stay driven
  assign supply_lost = !supply_ok_in && (state_reg != pis_pkg::PIS_OFF);

  pis_stage_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_in(sys_clk_in),
    .rst_b_in(rst_b),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .abort_in(supply_lost),
    .done_out(tmr_done)
  );

  // stage order; PIS_OFF leaves on supply on, PIS_RUN only on a supply drop, each other stage on its own completion or a supply drop
  always_comb
  begin
    state_next = state_reg;
    tmr_load = 1'b0;
    case (state_reg)
      pis_pkg::PIS_OFF:
      begin
        if (supply_ok_in)
        begin
          state_next = pis_pkg::PIS_NVM_RST;
          tmr_load = 1'b1;
        end
      end
      pis_pkg::PIS_NVM_RST:
      begin
        if (tmr_done)
          state_next = pis_pkg::PIS_CFG_LOAD;
      end
      pis_pkg::PIS_CFG_LOAD:
      begin
        if (cfg_load_done_in)
        begin
          state_next = pis_pkg::PIS_IN_RST;
          tmr_load = 1'b1;
        end
      end
      pis_pkg::PIS_IN_RST:
      begin
        if (tmr_done)
          state_next = pis_pkg::PIS_IN_EN;
      end
      pis_pkg::PIS_IN_EN:
      begin
        state_next = pis_pkg::PIS_LUT_RST;
        tmr_load = 1'b1;
      end
      pis_pkg::PIS_LUT_RST:
      begin
        if (tmr_done)
          state_next = pis_pkg::PIS_LUT_EN;
      end
      pis_pkg::PIS_LUT_EN:
      begin
        state_next = pis_pkg::PIS_SEQ_INIT;
        tmr_load = 1'b1;
      end
      pis_pkg::PIS_SEQ_INIT:
      begin
        if (tmr_done)
        begin
          state_next = pis_pkg::PIS_PWR_GOOD;
          tmr_load = 1'b1;
        end
      end
      pis_pkg::PIS_PWR_GOOD:
      begin
        if (tmr_done)
          state_next = pis_pkg::PIS_RUN;
      end
      pis_pkg::PIS_RUN:
      begin
        state_next = pis_pkg::PIS_RUN;
      end
      default:
      begin
        state_next = pis_pkg::PIS_OFF;
      end
    endcase
    if (supply_lost)
    begin
      state_next = pis_pkg::PIS_OFF;
      tmr_load = 1'b0;
    end
  end

  // length of the timed stage being entered
  always_comb
  begin
    tmr_count = pis_pkg::TMR_ZERO;
    case (state_next)
      pis_pkg::PIS_NVM_RST:
      begin
        tmr_count = TW'(NVM_RST_CYC);
      end
      pis_pkg::PIS_IN_RST:
      begin
        tmr_count = TW'(IN_RST_CYC);
      end
      pis_pkg::PIS_LUT_RST:
      begin
        tmr_count = TW'(LUT_RST_CYC);
      end
      pis_pkg::PIS_SEQ_INIT:
      begin
        tmr_count = TW'(SEQ_INIT_CYC);
      end
      pis_pkg::PIS_PWR_GOOD:
      begin
        tmr_count = TW'(OUT_REL_CYC);
      end
      default:
      begin
        tmr_count = pis_pkg::TMR_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= pis_pkg::PIS_OFF;
    else
      state_reg <= state_next;
  end

  // controls for the stage being entered
  always_comb
  begin
    ctrl_next = pis_pkg::CTRL_RESET;
    case (state_next)
      pis_pkg::PIS_OFF:
      begin
        ctrl_next = pis_pkg::CTRL_RESET;
      end
      pis_pkg::PIS_NVM_RST:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.macro_reset = 1'b1;
        ctrl_next.nvm_reset = 1'b1;
      end
      pis_pkg::PIS_CFG_LOAD:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.macro_reset = 1'b1;
        ctrl_next.cfg_load = 1'b1;
      end
      pis_pkg::PIS_IN_RST:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_reset = 1'b1;
        ctrl_next.lut_reset = 1'b1;
        ctrl_next.seq_reset = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
      end
      pis_pkg::PIS_IN_EN:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_enable = 1'b1;
        ctrl_next.analog_comparator_enable = 1'b1;
        ctrl_next.pull_enable = 1'b1;
        ctrl_next.lut_reset = 1'b1;
        ctrl_next.seq_reset = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
      end
      pis_pkg::PIS_LUT_RST:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_enable = 1'b1;
        ctrl_next.analog_comparator_enable = 1'b1;
        ctrl_next.pull_enable = 1'b1;
        ctrl_next.lut_reset = 1'b1;
        ctrl_next.seq_reset = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
      end
      pis_pkg::PIS_LUT_EN:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_enable = 1'b1;
        ctrl_next.analog_comparator_enable = 1'b1;
        ctrl_next.pull_enable = 1'b1;
        ctrl_next.lut_enable = 1'b1;
        ctrl_next.seq_reset = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
      end
      pis_pkg::PIS_SEQ_INIT:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_enable = 1'b1;
        ctrl_next.analog_comparator_enable = 1'b1;
        ctrl_next.pull_enable = 1'b1;
        ctrl_next.lut_enable = 1'b1;
        ctrl_next.seq_enable = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
      end
      pis_pkg::PIS_PWR_GOOD,
      pis_pkg::PIS_RUN:
      begin
        ctrl_next.macro_power = 1'b1;
        ctrl_next.in_enable = 1'b1;
        ctrl_next.analog_comparator_enable = 1'b1;
        ctrl_next.pull_enable = 1'b1;
        ctrl_next.lut_enable = 1'b1;
        ctrl_next.seq_enable = 1'b1;
        ctrl_next.edge_det_enable = 1'b1;
        ctrl_next.power_good = 1'b1;
      end
      default:
      begin
        ctrl_next = pis_pkg::CTRL_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_out <= pis_pkg::CTRL_RESET;
    else
      ctrl_out <= ctrl_next;
  end

  // input pins read low until enabled
  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      pin_to_matrix_out <= '0;
    else if (ctrl_next.in_enable)
      pin_to_matrix_out <= pin_level_in;
    else
      pin_to_matrix_out <= '0;
  end

  // lookup result reads low until the tables are active
  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      lut_to_matrix_out <= 1'b0;
    else
      lut_to_matrix_out <= ctrl_next.lut_enable && lut_result_in;
  end

  // output enables open on the edge that raises power-good
  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      pin_oe_out <= '0;
    else if (ctrl_next.power_good)
      pin_oe_out <= pin_is_output_in;
    else
      pin_oe_out <= '0;
  end

  // pins set as inputs never carry drive data
  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      pin_do_out <= '0;
    else if (ctrl_next.power_good)
      pin_do_out <= core_data_in & pin_is_output_in;
    else
      pin_do_out <= '0;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      init_busy_out <= 1'b0;
    else
      init_busy_out <= (state_next != pis_pkg::PIS_OFF) && !ctrl_next.power_good;
  end

endmodule

/* verif/pis_seq_checker.sv */
`timescale 1ns/100ps
module pis_seq_checker #(
  parameter int PIN_NUM = 9,
  parameter int NVM_RST_CYC = 1,
  parameter int IN_RST_CYC = 1,
  parameter int SEQ_INIT_CYC = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // watched inputs
  input wire logic supply_ok_in,
  input wire logic [PIN_NUM-1:0] pin_is_output_in,
  input wire logic [PIN_NUM-1:0] core_data_in,
  // watched outputs
  input wire pis_pkg::pis_ctrl_s ctrl_out,
  input wire logic [PIN_NUM-1:0] pin_to_matrix_out,
  input wire logic lut_to_matrix_out,
  input wire logic [PIN_NUM-1:0] pin_oe_out,
  input wire logic [PIN_NUM-1:0] pin_do_out,
  input wire logic init_busy_out
);
  localparam int NVM_LEN = NVM_RST_CYC + 1;
  localparam int IN_LEN = IN_RST_CYC + 1;
  localparam int SEQ_LEN = SEQ_INIT_CYC + 1;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // cycles spent in sequential init with power-good still low
  logic [7:0] seq_cnt;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      seq_cnt <= 8'h00;
    else if (ctrl_out.seq_enable && !ctrl_out.power_good)
      seq_cnt <= seq_cnt + 8'h01;
    else
      seq_cnt <= 8'h00;
  end

  a_pins_hiz_busy: assert property (init_busy_out |-> pin_oe_out == '0)
    else $error("pins driven during init");
  a_start_on_supply: assert property ($rose(init_busy_out) |-> $past(supply_ok_in)
    && ctrl_out.macro_power && ctrl_out.macro_reset && ctrl_out.nvm_reset)
    else $error("bad start stage");
  a_load_held_reset: assert property (ctrl_out.cfg_load |-> ctrl_out.macro_reset
    && ctrl_out.macro_power && !ctrl_out.nvm_reset && pin_oe_out == '0)
    else $error("load stage not held in reset");
  a_nvm_stage_len: assert property (disable iff (!rst_b_in || !supply_ok_in)
    $rose(ctrl_out.nvm_reset) |-> ##NVM_LEN ctrl_out.cfg_load && !ctrl_out.nvm_reset)
    else $error("memory reset length wrong");
  a_input_stage: assert property (disable iff (!rst_b_in || !supply_ok_in)
    $rose(ctrl_out.in_reset) |-> ##IN_LEN ctrl_out.in_enable && !ctrl_out.in_reset
    && ctrl_out.analog_comparator_enable && ctrl_out.pull_enable && !ctrl_out.lut_enable)
    else $error("input stage wrong");
  a_lut_order: assert property ($rose(ctrl_out.lut_enable) |-> $past(ctrl_out.lut_reset)
    && ctrl_out.in_enable && !ctrl_out.seq_enable)
    else $error("lookup tables out of order");
  a_seq_after_lut: assert property ($rose(ctrl_out.seq_enable) |->
    $past(ctrl_out.lut_enable) && !ctrl_out.power_good)
    else $error("sequential cells too early");
  a_good_after_init: assert property (disable iff (!rst_b_in || !supply_ok_in)
    $rose(ctrl_out.seq_enable) |-> ##SEQ_LEN ctrl_out.power_good
    && seq_cnt == 8'(SEQ_LEN))
    else $error("power good timing wrong");
  a_release_with_good: assert property ($rose(ctrl_out.power_good) |->
    pin_oe_out == $past(pin_is_output_in) && !init_busy_out)
    else $error("pins not released with power good");
  a_pin_follow: assert property (ctrl_out.power_good && $past(ctrl_out.power_good) |->
    pin_do_out == $past(core_data_in & pin_is_output_in))
    else $error("pin data does not follow core");
  a_matrix_low: assert property (!ctrl_out.in_enable && !$past(ctrl_out.in_enable) |->
    pin_to_matrix_out == '0)
    else $error("input pins not low");
  a_lut_low: assert property (!ctrl_out.lut_enable && !$past(ctrl_out.lut_enable) |->
    !lut_to_matrix_out)
    else $error("lookup output not low");
  a_edge_det_first: assert property ($rose(ctrl_out.edge_det_enable) |->
    ctrl_out.in_reset && !ctrl_out.in_enable && !ctrl_out.lut_enable)
    else $error("edge detector late");
  a_off_drop: assert property (!supply_ok_in && (init_busy_out || ctrl_out.power_good)
    |=> ctrl_out == '0 && pin_oe_out == '0 && !init_busy_out)
    else $error("power loss not handled");

  c_good: cover property ($rose(ctrl_out.power_good));
  c_abort_load: cover property (ctrl_out.cfg_load && !supply_ok_in);
  c_in_enable: cover property ($rose(ctrl_out.in_enable));
endmodule

bind pis_sequencer pis_seq_checker #(.PIN_NUM(PIN_NUM), .NVM_RST_CYC(NVM_RST_CYC),
  .IN_RST_CYC(IN_RST_CYC), .SEQ_INIT_CYC(SEQ_INIT_CYC)) i_chk (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .supply_ok_in(supply_ok_in),
  .pin_is_output_in(pin_is_output_in), .core_data_in(core_data_in), .ctrl_out(ctrl_out),
  .pin_to_matrix_out(pin_to_matrix_out), .lut_to_matrix_out(lut_to_matrix_out),
  .pin_oe_out(pin_oe_out), .pin_do_out(pin_do_out), .init_busy_out(init_busy_out));

/* verif/pis_fabric_model.sv */
`timescale 1ns/100ps
// memory copy with a chosen latency, plus moving pad and table levels
module pis_fabric_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control from the sequencer and the chosen copy latency
  input wire pis_pkg::pis_ctrl_s ctrl_in,
  input wire logic [7:0] load_dly_in,
  // answers
  output logic cfg_done_out,
  output logic [8:0] pin_level_out,
  output logic lut_result_out
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg <= 8'h00;
      cfg_done_out <= 1'b0;
    end
    else if (!ctrl_in.cfg_load)
    begin
      cnt_reg <= 8'h00;
      cfg_done_out <= 1'b0;
    end
    else if (cnt_reg == load_dly_in)
      cfg_done_out <= 1'b1;
    else
      cnt_reg <= cnt_reg + 8'h01;
  end

  // levels change every cycle so stale values show
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pin_level_out <= 9'h0A5;
    else
      pin_level_out <= {pin_level_out[7:0], ~pin_level_out[8]};
  end

  assign lut_result_out = ^pin_level_out;
endmodule

/* verif/power_on_init_sequencer_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module power_on_init_sequencer_tb_top;
  localparam int NVM = 3;
  localparam int INR = 2;
  localparam int LUT = 2;
  localparam int SEQ = 3;
  // cyc: edges from supply on to power-good for that memory copy latency
  typedef struct {logic [8:0] dir; logic [8:0] dat; logic [7:0] dly; int cyc;} pis_row_s;
  pis_row_s rows[4] = '{'{9'h1FF, 9'h155, 8'h00, 19}, '{9'h0F0, 9'h0FF, 8'h03, 22},
    '{9'h000, 9'h1FF, 8'h01, 20}, '{9'h121, 9'h0A5, 8'h06, 25}};
  logic sys_clk, rst_b, supply_ok, cfg_done, lut_res, l2m, busy;
  logic [8:0] pin_dir, core_data, pin_level, p2m, oe, dout;
  logic [7:0] load_dly;
  pis_pkg::pis_ctrl_s ctrl;
  int fail_count = 0;
  int comparisons = 0;

  pis_sequencer #(.NVM_RST_CYC(NVM), .IN_RST_CYC(INR), .LUT_RST_CYC(LUT),
    .SEQ_INIT_CYC(SEQ)) i_dut (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .supply_ok_in(supply_ok),
    .cfg_load_done_in(cfg_done), .pin_is_output_in(pin_dir), .core_data_in(core_data),
    .pin_level_in(pin_level), .lut_result_in(lut_res), .ctrl_out(ctrl),
    .pin_to_matrix_out(p2m), .lut_to_matrix_out(l2m), .pin_oe_out(oe),
    .pin_do_out(dout), .init_busy_out(busy));

  pis_fabric_model i_fabric (
    .clk_in(sys_clk), .rst_b_in(rst_b), .ctrl_in(ctrl), .load_dly_in(load_dly),
    .cfg_done_out(cfg_done), .pin_level_out(pin_level), .lut_result_out(lut_res));

  always #10 sys_clk = ~sys_clk;

  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bring_up(input pis_row_s r);
    logic [8:0] lv;
    logic lr;
    int n;
    pin_dir = r.dir;
    core_data = r.dat;
    load_dly = r.dly;
    supply_ok = 1'b1;
    n = 0;
    while (ctrl.power_good !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
      if (ctrl.power_good !== 1'b1)
        `CHK("init_oe", 9'h000, oe)
    end
    `CHK("cycles", r.cyc, n)
    `CHK("cycles_sum", NVM + INR + LUT + SEQ + 9 + r.dly, n)
    `CHK("oe", r.dir, oe)
    `CHK("busy", 1'b0, busy)
    core_data = ~r.dat;
    lv = pin_level;
    lr = lut_res;
    @(negedge sys_clk);
    `CHK("dout", ~r.dat & r.dir, dout)
    `CHK("matrix", lv, p2m)
    `CHK("lut", lr, l2m)
    supply_ok = 1'b0;
    @(negedge sys_clk);
    `CHK("off_ctrl", 14'h0000, ctrl)
    `CHK("off_oe", 9'h000, oe)
    @(negedge sys_clk);
  endtask

  initial
  begin
    int n;
    sys_clk = 1'b0;
    rst_b = 1'b0;
    supply_ok = 1'b0;
    pin_dir = 9'h000;
    core_data = 9'h000;
    load_dly = 8'h02;
    repeat (12) @(negedge sys_clk);
    `CHK("rst_ctrl", 14'h0000, ctrl)
    `CHK("rst_oe", 9'h000, oe)
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    foreach (rows[i])
      bring_up(rows[i]);
    // power lost in the first cycle of a slow memory copy
    load_dly = 8'h14;
    supply_ok = 1'b1;
    n = 0;
    while (ctrl.cfg_load !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("load_reset", 1'b1, ctrl.macro_reset)
    `CHK("load_oe", 9'h000, oe)
    supply_ok = 1'b0;
    @(negedge sys_clk);
    `CHK("abort_ctrl", 14'h0000, ctrl)
    `CHK("abort_busy", 1'b0, busy)
    @(negedge sys_clk);
    bring_up(rows[3]);
    summarize();
  end

  // whole run needs about 150 cycles; allow over sixteen times that
  initial
  begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule
